// >>> hdl/asr_host.sv
// host controller driving an ecc static ram over its asynchronous pins
// Functional notes
// [R1] chip enabled only with low-active select low and high-active select high
// [R2] write window opens with all enables low; first to rise ends it
// [R3] data set up before and held past the edge ending the write
// [R4] device releases data lines when output enable or byte enables high
// [R5] enable and write strobe rising together leave outputs released
// [R6] host never drives data while device may still drive it
// [R7] write strobe low at least turn-off time plus data setup
// [R8] write enable held high through every read
// [R9] address valid no later than chip enable going active
// [R10] read data taken from lanes whose byte enable is low
// [R11] write stores lanes whose enable is low, others unchanged
// [R12] selected with both strobes high leaves data lines released
// [R13] error flag low on a clean read
// [R14] error flag high when a single-bit error was corrected
// [R15] error flag released when deselected, outputs off, or writing
// [R16] idle with chip deselected and all byte enables high
// [R17] device keeps check bits and returns corrected read data
`timescale 1ns/100ps
`default_nettype none
module asr_host
    import asr_pkg::*;
(
    input  wire logic              core_clk,
    input  wire logic              rst,
    input  wire logic              reqValid,
    input  wire logic              reqWrite,
    input  wire logic [ADDR_W-1:0] reqAddr,
    input  wire logic [DATA_W-1:0] reqWdata,
    input  wire logic [LANES-1:0]  reqLanes,
    output logic                   reqReady,
    output logic                   rspValid,
    output logic [DATA_W-1:0]      rspRdata,
    output logic                   rspCorrected,
    output logic [ADDR_W-1:0]      sramAddr,
    output logic                   sramSelLowActive_n,
    output logic                   sramSelHighActive,
    output logic                   sramOutEn_n,
    output logic                   sramWrEn_n,
    output logic [LANES-1:0]       sramByteEn_n,
    output logic [DATA_W-1:0]      sramDataOut,
    output logic                   sramDataOe,
    input  wire logic [DATA_W-1:0] sramDataIn,
    input  wire logic              sramErrIn
);
    // ==========================================================
    // pin synchronisers
    logic [DATA_W:0] pinSync;
    asr_sync #(.W(DATA_W + 1)) uSync (
        .core_clk (core_clk),
        .rst      (rst),
        .asyncIn  ({sramErrIn, sramDataIn}),
        .syncOut  (pinSync)
    );

    // ==========================================================
    // sequencer
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_RSET  = 3'b001,
        ST_READ  = 3'b011,
        ST_TURN  = 3'b010,
        ST_WSET  = 3'b110,
        ST_WSTB  = 3'b111,
        ST_WHOLD = 3'b101
    } asr_state_t;

    asr_state_t        state_q, state_d;
    logic [CNT_W-1:0]  cnt_q, cnt_d;
    logic [ADDR_W-1:0] addr_q, addr_d;
    logic [DATA_W-1:0] wdat_q, wdat_d;
    logic [LANES-1:0]  be_q, be_d;
    logic              csn_q, csn_d, cs_q, cs_d;
    logic              oen_q, oen_d, wen_q, wen_d, doe_q, doe_d;
    logic              rdy_q, rdy_d, rv_q, rv_d, err_q, err_d;
    logic [DATA_W-1:0] rdat_q, rdat_d;
    logic [DATA_W-1:0] laneMask;

    genvar g;
    generate
        for (g = 0; g < LANES; g++) begin : gLane
            assign laneMask[g*LANE_W +: LANE_W] = {LANE_W{~be_q[g]}};
        end
    endgenerate

    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        addr_d  = addr_q;
        wdat_d  = wdat_q;
        be_d    = be_q;
        csn_d   = csn_q;
        cs_d    = cs_q;
        oen_d   = oen_q;
        wen_d   = wen_q;
        doe_d   = doe_q;
        rdy_d   = rdy_q;
        rv_d    = 1'b0;
        err_d   = err_q;
        rdat_d  = rdat_q;
        unique case (state_q)
            ST_IDLE: begin
                if (reqValid && rdy_q) begin
                    // [R9] address settled first
                    addr_d = reqAddr;
                    wdat_d = reqWdata;
                    be_d   = ~reqLanes;
                    rdy_d  = 1'b0;
                    cnt_d  = CNT_W'(SU_CYC);
                    state_d = reqWrite ? ST_WSET : ST_RSET;
                end
            end
            ST_RSET: begin
                // [R1] [R8] select with write strobe high
                csn_d = 1'b0;
                cs_d  = 1'b1;
                oen_d = 1'b0;
                cnt_d = CNT_W'(RD_CYC + SYNC_LAG);
                state_d = ST_READ;
            end
            ST_READ: begin
                if (cnt_q != '0) begin
                    cnt_d = cnt_q - 1'b1;
                end else begin
                    // [R10] [R17] keep enabled lanes only
                    rdat_d = pinSync[DATA_W-1:0] & laneMask;
                    // [R13] [R14] flag sampled during read
                    err_d = pinSync[DATA_W];
                    rv_d  = 1'b1;
                    oen_d = 1'b1;
                    csn_d = 1'b1;
                    cs_d  = 1'b0;
                    be_d  = LANES_OFF;
                    cnt_d = CNT_W'(TA_CYC);
                    state_d = ST_TURN;
                end
            end
            ST_TURN: begin
                // [R6] let device drivers fall off before next cycle
                if (cnt_q != '0) begin
                    cnt_d = cnt_q - 1'b1;
                end else begin
                    rdy_d = 1'b1;
                    state_d = ST_IDLE;
                end
            end
            ST_WSET: begin
                // [R6] outputs stay disabled so host may drive at once
                csn_d = 1'b0;
                cs_d  = 1'b1;
                doe_d = 1'b1;
                cnt_d = CNT_W'(WE_CYC);
                state_d = ST_WSTB;
            end
            ST_WSTB: begin
                // [R2] [R7] [R11] strobe low long enough
                wen_d = 1'b0;
                if (cnt_q != '0) begin
                    cnt_d = cnt_q - 1'b1;
                end else begin
                    // [R3] write ends on strobe alone, data still held
                    wen_d = 1'b1;
                    cnt_d = CNT_W'(HD_CYC);
                    state_d = ST_WHOLD;
                end
            end
            ST_WHOLD: begin
                if (cnt_q != '0) begin
                    cnt_d = cnt_q - 1'b1;
                end else begin
                    // [R16] back to standby
                    doe_d = 1'b0;
                    csn_d = 1'b1;
                    cs_d  = 1'b0;
                    be_d  = LANES_OFF;
                    rdy_d = 1'b1;
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_q <= ST_IDLE;
            cnt_q   <= '0;
            addr_q  <= '0;
            wdat_q  <= '0;
            be_q    <= LANES_OFF;
            csn_q   <= 1'b1;
            cs_q    <= 1'b0;
            oen_q   <= 1'b1;
            wen_q   <= 1'b1;
            doe_q   <= 1'b0;
            rdy_q   <= 1'b1;
            rv_q    <= 1'b0;
            err_q   <= 1'b0;
            rdat_q  <= '0;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            addr_q  <= addr_d;
            wdat_q  <= wdat_d;
            be_q    <= be_d;
            csn_q   <= csn_d;
            cs_q    <= cs_d;
            oen_q   <= oen_d;
            wen_q   <= wen_d;
            doe_q   <= doe_d;
            rdy_q   <= rdy_d;
            rv_q    <= rv_d;
            err_q   <= err_d;
            rdat_q  <= rdat_d;
        end
    end

    assign reqReady           = rdy_q;
    assign rspValid           = rv_q;
    assign rspRdata           = rdat_q;
    assign rspCorrected       = err_q;
    assign sramAddr           = addr_q;
    assign sramSelLowActive_n = csn_q;
    assign sramSelHighActive  = cs_q;
    assign sramOutEn_n        = oen_q;
    assign sramWrEn_n         = wen_q;
    assign sramByteEn_n       = be_q;
    assign sramDataOut        = wdat_q;
    assign sramDataOe         = doe_q;

    // ==========================================================
    // checks
    // [R8] strobe high in reads
    AST_WE_HIGH_IN_READ: assert property ( // [R8]
        @(posedge core_clk) disable iff (rst) !oen_q |-> wen_q)
        else $error("write strobe low during read");
    // [R6] no bus fight
    AST_NO_FIGHT: assert property ( // [R6]
        @(posedge core_clk) disable iff (rst) doe_q |-> oen_q)
        else $error("host drives while outputs on");
    // [R7] strobe pulse width
    // nine cycles of 5 ns cover turn-off plus data setup
    AST_STROBE_WIDTH: assert property ( // [R7]
        @(posedge core_clk) disable iff (rst)
        $fell(wen_q) |-> !wen_q [*8] ##1 !wen_q)
        else $error("strobe too short");
    // [R2] write only while selected
    AST_SELECT_IN_WRITE: assert property ( // [R2]
        @(posedge core_clk) disable iff (rst)
        !wen_q |-> (!csn_q && cs_q && doe_q))
        else $error("bad write");
    // [R3] data held past strobe
    AST_DATA_HOLD: assert property ( // [R3]
        @(posedge core_clk) disable iff (rst)
        $rose(wen_q) |-> doe_q && $stable(wdat_q))
        else $error("no hold");
    // [R9] address steady while selected
    AST_ADDR_STABLE: assert property ( // [R9]
        @(posedge core_clk) disable iff (rst)
        (!csn_q && $past(!csn_q)) |-> $stable(addr_q))
        else $error("address moved while selected");
    // [R16] standby when idle
    AST_IDLE_STANDBY: assert property ( // [R16]
        @(posedge core_clk) disable iff (rst)
        (state_q == ST_IDLE) |-> (csn_q && !cs_q && be_q == LANES_OFF))
        else $error("not in standby");
    // [R10] answer only after a read
    AST_RSP_AFTER_READ: assert property ( // [R10]
        @(posedge core_clk) disable iff (rst)
        rspValid |-> $past(!oen_q))
        else $error("response without read");
endmodule
`default_nettype wire

// >>> hdl/asr_pkg.sv
// package: pin-level constants and timing counts for the sram host controller
package asr_pkg;
    localparam int ADDR_W = 19;
    localparam int DATA_W = 32;
    localparam int LANES  = 4;
    localparam int LANE_W = 8;
    localparam int CLK_PERIOD_NS = 5;
    // device timing in ns (slow grade, safe for both)
    localparam int T_RC_NS   = 55;
    localparam int T_AA_NS   = 55;
    localparam int T_WC_NS   = 55;
    localparam int T_PWE_NS  = 40;
    localparam int T_HZWE_NS = 20;
    localparam int T_SD_NS   = 25;
    localparam int T_HZOE_NS = 18;
    localparam int T_SA_NS   = 0;
    localparam int T_HD_NS   = 0;
    // two synchroniser flops delay every pin sample
    localparam int SYNC_LAG  = 2;
    // least times round up, never below one cycle
    function automatic int cyc_up(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction
    localparam int RD_CYC   = cyc_up(T_AA_NS) + 1;
    localparam int WE_CYC_A = cyc_up(T_PWE_NS);
    localparam int WE_CYC_B = cyc_up(T_HZWE_NS + T_SD_NS);
    localparam int WE_CYC   = (WE_CYC_A > WE_CYC_B) ? WE_CYC_A : WE_CYC_B;
    localparam int SU_CYC   = cyc_up(T_SA_NS);
    localparam int HD_CYC   = cyc_up(T_HD_NS);
    localparam int TA_CYC   = cyc_up(T_HZOE_NS);
    localparam int CNT_W    = 5;
    localparam logic [LANES-1:0] LANES_OFF = 4'hF;
endpackage

// >>> hdl/asr_sync.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/100ps
`default_nettype none
module asr_sync #(
    parameter int W = 1
) (
    input  wire logic         core_clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] asyncIn,
    output var  logic [W-1:0] syncOut
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= asyncIn;
            sync_q <= meta_q;
        end
    end
    assign syncOut = sync_q;
endmodule
`default_nettype wire

// >>> verif/asr_sram_model.sv
// ecc static ram pin model with error injection and host timing checks
`timescale 1ns/100ps
`default_nettype none
module asr_sram_model
    import asr_pkg::*;
#(
    parameter int ACC_NS = T_AA_NS
) (
    input  wire logic [ADDR_W-1:0] sramAddr,
    input  wire logic              sramSelLowActive_n,
    input  wire logic              sramSelHighActive,
    input  wire logic              sramOutEn_n,
    input  wire logic              sramWrEn_n,
    input  wire logic [LANES-1:0]  sramByteEn_n,
    input  wire logic [DATA_W-1:0] sramDataOut,
    input  wire logic              sramDataOe,
    input  wire logic              injectErr,
    output logic [DATA_W-1:0]      busLevel,
    output logic                   errLevel,
    output logic                   fault
);
    logic [DATA_W-1:0] mem [int];
    logic [DATA_W-1:0] stored, wData;
    logic [ADDR_W-1:0] wAddr;
    logic [LANES-1:0]  wBe, drv;
    logic [ADDR_W+1:0] keyDly;
    int                nWr = 0;
    realtime           weFall = 0;
    wire logic ce = !sramSelLowActive_n && sramSelHighActive;
    wire logic [ADDR_W+1:0] key = {sramAddr, ce, sramOutEn_n};
    wire logic wrOn = ce && !sramWrEn_n && (sramByteEn_n != LANES_OFF);
    // inertial delay: read data is junk until the access time has passed
    assign #(ACC_NS) keyDly = key;
    initial fault = 1'b0;
    // data taken up to the edge ending the write
    always @* begin
        if (wrOn) begin
            wAddr = sramAddr;
            wBe   = sramByteEn_n;
            wData = busLevel;
        end
    end
    always @(negedge wrOn) begin
        logic [DATA_W-1:0] w;
        w = mem.exists(wAddr) ? mem[wAddr] : 32'h0;
        for (int i = 0; i < LANES; i++)
            if (!wBe[i]) w[i*LANE_W +: LANE_W] = wData[i*LANE_W +: LANE_W];
        mem[wAddr] = w;
        nWr++;
    end
    always @(sramAddr, nWr)
        stored = mem.exists(sramAddr) ? mem[sramAddr] : 32'hC3C3_C3C3;
    // lanes driven only on a selected read
    always @* begin
        int s;
        s = 0;
        for (int i = 0; i < LANES; i++) begin
            s = i * LANE_W;
            drv[i] = ce && !sramOutEn_n && sramWrEn_n && !sramByteEn_n[i];
            if (sramDataOe)
                busLevel[s +: LANE_W] = drv[i] ? 'x : sramDataOut[s +: LANE_W];
            else if (drv[i] && keyDly === key)
                busLevel[s +: LANE_W] = stored[s +: LANE_W];
            else
                busLevel[s +: LANE_W] = ~stored[s +: LANE_W];
        end
    end
    // flag driven only on a selected read
    always @* begin
        if (ce && !sramOutEn_n && sramWrEn_n && sramByteEn_n != LANES_OFF)
            errLevel = (keyDly === key) ? injectErr : !injectErr;
        else
            errLevel = !injectErr;
    end
    // both sides driving the data lines
    always @* if (sramDataOe === 1'b1 && drv != 4'h0) fault = 1'b1;
    always @(negedge sramWrEn_n) weFall = $realtime;
    // strobe width with output enable low
    always @(posedge sramWrEn_n)
        if (!sramOutEn_n && $realtime - weFall < T_HZWE_NS + T_SD_NS)
            fault = 1'b1;
    // address moving inside a selected read
    always @(sramAddr) if (ce && !sramOutEn_n) fault = 1'b1;
endmodule
`default_nettype wire

// >>> verif/tb.sv
// testbench: sram host controller against the device model
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e, m) begin check_count++; if ((a) !== (e)) begin \
    errors++; $display("wrong value at %0t: %s", $time, m); end end
module tb
    import asr_pkg::*;
;
    logic              core_clk, rst, reqValid, reqWrite, injectErr, cor;
    logic [ADDR_W-1:0] reqAddr, sramAddr;
    logic [DATA_W-1:0] reqWdata, rspRdata, sramDataOut, busLevel, rd;
    logic [LANES-1:0]  reqLanes, sramByteEn_n;
    logic              reqReady, rspValid, rspCorrected, errLevel, fault;
    logic              sramSelLowActive_n, sramSelHighActive, sramOutEn_n;
    logic              sramWrEn_n, sramDataOe;
    int                errors = 0;
    int                check_count = 0;
    wire logic sel = !sramSelLowActive_n && sramSelHighActive;
    asr_host uut (
        .core_clk, .rst, .reqValid, .reqWrite, .reqAddr, .reqWdata,
        .reqLanes, .reqReady, .rspValid, .rspRdata, .rspCorrected,
        .sramAddr, .sramSelLowActive_n, .sramSelHighActive, .sramOutEn_n,
        .sramWrEn_n, .sramByteEn_n, .sramDataOut, .sramDataOe,
        .sramDataIn(busLevel), .sramErrIn(errLevel)
    );
    asr_sram_model #(.ACC_NS(T_AA_NS)) dev (
        .sramAddr, .sramSelLowActive_n, .sramSelHighActive, .sramOutEn_n,
        .sramWrEn_n, .sramByteEn_n, .sramDataOut, .sramDataOe, .injectErr,
        .busLevel, .errLevel, .fault
    );
    initial begin
        core_clk = 1'b0;
        forever #(CLK_PERIOD_NS / 2.0) core_clk = ~core_clk;
    end
    // some twenty-two transfers of fourteen to twenty-two cycles, wide margin
    initial begin
        #(CLK_PERIOD_NS * 5000);
        errors++;
        $display("wrong value at %0t: watchdog expired", $time);
        print_verdict();
    end
    always @(posedge core_clk) begin
        if (!rst && sramWrEn_n === 1'b0) `CHK(sel, 1'b1, "strobe unselected")
        if (!rst && sramOutEn_n === 1'b0) `CHK(sramWrEn_n, 1'b1, "we in read")
    end
    // one request, held until taken; reads wait for the answer
    task automatic xfer(input logic w, input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] d, input logic [LANES-1:0] l);
        int n;
        reqValid <= 1'b1;
        reqWrite <= w;
        reqAddr  <= a;
        reqWdata <= d;
        reqLanes <= l;
        n = 0;
        do begin @(posedge core_clk); n++; end while (!reqReady && n < 60);
        `CHK(reqReady, 1'b1, "request not taken")
        reqValid <= 1'b0;
        n = 0;
        if (w) @(posedge core_clk);
        else begin
            do begin @(posedge core_clk); n++; end while (!rspValid && n < 60);
            `CHK(rspValid, 1'b1, "no read answer")
            rd  = rspRdata;
            cor = rspCorrected;
        end
    endtask
    task automatic t_idle;
        `CHK({sramSelLowActive_n, sramSelHighActive}, 2'b10, "select")
        `CHK({sramOutEn_n, sramWrEn_n}, 2'b11, "strobes idle")
        `CHK(sramByteEn_n, LANES_OFF, "lanes idle")
        `CHK({sramDataOe, reqReady}, 2'b01, "bus idle")
        `CHK(fault, 1'b0, "host pin timing")
        $display("test idle done");
    endtask
    task automatic t_full;
        xfer(1'b1, 19'h7FFFF, 32'h1234_5678, 4'hF);
        xfer(1'b1, 19'h00000, 32'h9ABC_DEF0, 4'hF);
        xfer(1'b0, 19'h7FFFF, 32'h0, 4'hF);
        `CHK(rd, 32'h1234_5678, "top word")
        `CHK(cor, 1'b0, "clean flag")
        xfer(1'b0, 19'h00000, 32'h0, 4'hF);
        `CHK(rd, 32'h9ABC_DEF0, "bottom word")
        $display("test full done");
    endtask
    task automatic t_lanes;
        logic [DATA_W-1:0] exp;
        for (int i = 0; i < LANES; i++) begin
            xfer(1'b1, 19'h00040, 32'h3C3C_3C3C, 4'hF);
            xfer(1'b1, 19'h00040, 32'hA5A5_A5A5, 4'h1 << i);
            exp = 32'h3C3C_3C3C;
            exp[i*LANE_W +: LANE_W] = 8'hA5;
            xfer(1'b0, 19'h00040, 32'h0, 4'hF);
            `CHK(rd, exp, "lane merge")
            xfer(1'b0, 19'h00040, 32'h0, 4'h1 << i);
            `CHK(rd, 32'hA5 << (i * LANE_W), "lane read")
        end
        $display("test lanes done");
    endtask
    task automatic t_err;
        injectErr <= 1'b1;
        xfer(1'b0, 19'h7FFFF, 32'h0, 4'hF);
        `CHK(rd, 32'h1234_5678, "corrected word")
        `CHK(cor, 1'b1, "flag raised")
        injectErr <= 1'b0;
        xfer(1'b0, 19'h7FFFF, 32'h0, 4'h2);
        `CHK(rd, 32'h0000_5600, "single lane")
        `CHK(cor, 1'b0, "flag cleared")
        $display("test err done");
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        rst = 1'b1;
        reqValid = 1'b0;
        reqWrite = 1'b0;
        reqAddr = 19'h0;
        reqWdata = 32'h0;
        reqLanes = 4'h0;
        injectErr = 1'b0;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        t_idle();
        t_full();
        t_lanes();
        t_err();
        repeat (TA_CYC + 2) @(posedge core_clk);
        t_idle();
        print_verdict();
    end
endmodule
`default_nettype wire
